// ---- ppsc_pkg.sv ----
// Constants and types shared by the power-state controller files
package ppsc_pkg;
  // ==========================================
  // Register map
  localparam logic [15:0] ADDR_CFG = 16'h018b;
  localparam logic [15:0] ADDR_CMD = 16'h018c;
  localparam logic [15:0] ADDR_PREP_A = 16'h041e;
  localparam logic [15:0] ADDR_PREP_B = 16'h042f;
  localparam int CFG_AUTON_BIT = 6;
  localparam int CFG_SLEEP_BIT = 7;
  localparam int CFG_REMOTE_BIT = 8;
  localparam logic [15:0] CMD_TO_NORMAL = 16'h0001;
  localparam logic [15:0] CMD_TO_STANDBY = 16'h0010;
  localparam logic [15:0] PREP_A_SLEEP = 16'h0100;
  localparam logic [15:0] PREP_B_SLEEP = 16'h0007;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] PREP_RST = 16'h0000;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_HOLD_NS = 1250000;
  localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================
  // Serial management frame
  localparam logic [5:0] MDIO_PRE_BITS = 6'h20;
  localparam logic [4:0] HDR_DECODE_IDX = 5'h0c;
  localparam logic [4:0] HDR_TA_IDX = 5'h0d;
  localparam logic [4:0] HDR_LAST_IDX = 5'h0e;
  localparam logic [4:0] DAT_LAST_IDX = 5'h0f;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_RDINC = 2'h2;
  typedef enum logic [1:0] {
    PH_PRE = 2'h0,
    PH_HDR = 2'h1,
    PH_DAT = 2'h3
  } ppsc_phase_t;
  typedef enum logic [1:0] {
    ST_STANDBY = 2'h0,
    ST_NORMAL = 2'h1,
    ST_SLEEP_WAIT = 2'h3,
    ST_SLEEP = 2'h2
  } ppsc_state_t;
endpackage

// ---- ppsc_mgmt_if.sv ----
// Register access path between the management port and the register file
`timescale 1ns/100ps
interface ppsc_mgmt_if;
  logic wr_stb;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic enable;
  modport port (output wr_stb, addr, wdata, input rdata, enable);
  modport regs (input wr_stb, addr, wdata, output rdata, enable);
endinterface

// ---- ppsc_mgmt_port.sv ----
// Serial management port: indirect-address frames onto the register path
`timescale 1ns/100ps
module ppsc_mgmt_port #(
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  ppsc_mgmt_if.port bus
);
  logic mdc_q_r;
  logic rise;
  logic [5:0] ones_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [15:0] tx_r;
  logic [15:0] addr_r;
  logic [15:0] wdata_r;
  logic wr_r;
  logic [1:0] op_r;
  logic hit_r;
  ppsc_pkg::ppsc_phase_t ph_r;

  assign rise = mdc && !mdc_q_r;
  assign sh_nxt = {sh_r[14:0], mdio_in};
  assign bus.wr_stb = wr_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // Reset high, so a clock pin left high gives no false edge
      mdc_q_r <= 1'b1;
    end else begin
      mdc_q_r <= mdc;
    end
  end

  // ==========================================
  // Frame tracking
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ph_r <= ppsc_pkg::PH_PRE;
      ones_r <= 6'h00;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      op_r <= 2'h0;
      hit_r <= 1'b0;
    end else if (!bus.enable) begin
      ph_r <= ppsc_pkg::PH_PRE;
      ones_r <= 6'h00;
      hit_r <= 1'b0;
    end else if (rise) begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_r + 5'h01;
      unique case (ph_r)
        ppsc_pkg::PH_PRE: begin
          if (!mdio_in) begin
            ones_r <= 6'h00;
          end else if (ones_r != ppsc_pkg::MDIO_PRE_BITS) begin
            ones_r <= ones_r + 6'h01;
          end
          if (!mdio_in && ones_r == ppsc_pkg::MDIO_PRE_BITS) begin
            ph_r <= ppsc_pkg::PH_HDR;
            cnt_r <= 5'h00;
          end
        end
        ppsc_pkg::PH_HDR: begin
          if (cnt_r == ppsc_pkg::HDR_DECODE_IDX) begin
            op_r <= sh_nxt[11:10];
            hit_r <= !sh_nxt[12] && sh_nxt[9:5] == PORT_ADDR;
          end
          if (cnt_r == ppsc_pkg::HDR_LAST_IDX) begin
            ph_r <= ppsc_pkg::PH_DAT;
            cnt_r <= 5'h00;
          end
        end
        ppsc_pkg::PH_DAT: begin
          if (cnt_r == ppsc_pkg::DAT_LAST_IDX) begin
            ph_r <= ppsc_pkg::PH_PRE;
            ones_r <= 6'h00;
          end
        end
        default: ph_r <= ppsc_pkg::PH_PRE;
      endcase
    end
  end

  // ==========================================
  // Read drive: zero in second turnaround bit, then data msb first
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
      tx_r <= 16'h0000;
    end else if (!bus.enable) begin
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end else if (rise) begin
      if (ph_r == ppsc_pkg::PH_HDR && cnt_r == ppsc_pkg::HDR_TA_IDX && hit_r && op_r[1]) begin
        mdio_oe <= 1'b1;
        mdio_out <= 1'b0;
        tx_r <= bus.rdata;
      end else if (mdio_oe && !(ph_r == ppsc_pkg::PH_DAT && cnt_r == ppsc_pkg::DAT_LAST_IDX)) begin
        mdio_out <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end else begin
        mdio_oe <= 1'b0;
        mdio_out <= 1'b0;
      end
    end
  end

  // ==========================================
  // Frame end actions
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 16'h0000;
    end else begin
      wr_r <= 1'b0;
      if (rise && hit_r && ph_r == ppsc_pkg::PH_DAT && cnt_r == ppsc_pkg::DAT_LAST_IDX) begin
        if (op_r == ppsc_pkg::OP_ADDR) begin
          addr_r <= sh_nxt;
        end else if (op_r == ppsc_pkg::OP_WRITE) begin
          wr_r <= 1'b1;
          wdata_r <= sh_nxt;
        end else if (op_r == ppsc_pkg::OP_RDINC) begin
          addr_r <= addr_r + 16'h0001;
        end
      end
    end
  end
endmodule

// ---- ppsc_wake_qual.sv ----
// Qualifies a wake pattern from the line by its minimum hold time
`timescale 1ns/100ps
module ppsc_wake_qual #(
  parameter int HOLD_CYC = ppsc_pkg::WAKE_HOLD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic pattern,
  output logic wake_r
);
  localparam int CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_r;

  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("HOLD_CYC must be at least one");
  end

  // Any gap in the pattern restarts the count
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      wake_r <= 1'b0;
    end else begin
      wake_r <= 1'b0;
      if (!enable || !pattern) begin
        cnt_r <= '0;
      end else if (cnt_r == CW'(HOLD_CYC - 1)) begin
        wake_r <= 1'b1;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end

  hold_time_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wake_r |-> $past(pattern) && $past(enable) && $past(cnt_r) == CW'(HOLD_CYC - 1))
    else $error("wake pulse without full hold time");
  pattern_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pattern |=> cnt_r == '0 && !wake_r)
    else $error("hold count survived a pattern gap");
endmodule

// ---- ppsc_top.sv ----
// Power-state controller: standby, normal and sleep for a single-pair PHY
//
// Summary of operation
// - After any reset, managed strap leaves the device in standby, either role.
// - Standby keeps coding and attachment sublayers off; management still works.
// - Autonomous strap moves the device to normal right after reset.
// - Writing the autonomous bit of power_mode_config acts like the strap.
// - Managed standby leaves for normal only on command value 0x001 or a write that sets the autonomous bit.
// - Command value 0x0010 forces normal back to standby.
// - Normal enables all functions; link attempts start at once.
// - Sleep disables all but energy detection and loses every register.
// - Sleep is entered only after the supply inhibit removed the supplies.
// - Linked master with remote and sleep bits, wake low, sleeps on energy loss.
// - Slave with sleep bit and wake low sleeps once master goes quiet.
// - Wake input high leaves sleep in either role.
// - Send-S from the partner for 1.25 ms leaves sleep.
// - Send-T from the partner is an equal sleep exit trigger.
`timescale 1ns/100ps
module ppsc_top #(
  parameter int WAKE_HOLD_CYC = ppsc_pkg::WAKE_HOLD_CYC,
  parameter logic [4:0] PORT_ADDR = 5'h00
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic strap_autonomous,
  input wire logic strap_master,
  input wire logic wake_in,
  input wire logic energy_det,
  input wire logic send_s_det,
  input wire logic send_t_det,
  input wire logic supply_off,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  output logic supply_inhibit_out,
  output logic pcs_pma_en,
  output logic [1:0] power_state
);
  // ==========================================
  // Declarations
  ppsc_mgmt_if bus ();
  ppsc_pkg::ppsc_state_t state_r;
  ppsc_pkg::ppsc_state_t state_nxt;
  logic boot_r;
  logic master_r;
  logic auton_strap_r;
  logic en_r;
  logic [15:0] cfg_r;
  logic [15:0] cmd_r;
  logic [15:0] prep_a_r;
  logic [15:0] prep_b_r;
  logic wr_cfg;
  logic wr_cmd;
  logic wr_prep_a;
  logic wr_prep_b;
  logic cmd_start;
  logic cmd_stop;
  logic auton_set;
  logic armed;
  logic prep_ok;
  logic local_go;
  logic remote_go;
  logic sleep_go;
  logic line_wake;

  function automatic logic reg_hit(input logic [15:0] addr, input logic [15:0] target);
    reg_hit = addr == target;
  endfunction

  // ==========================================
  // Submodules
  ppsc_mgmt_port #(
    .PORT_ADDR(PORT_ADDR)
  ) u_port (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .bus(bus.port)
  );

  // Only energy detection stays alive in sleep, so it gates the pattern
  ppsc_wake_qual #(
    .HOLD_CYC(WAKE_HOLD_CYC)
  ) u_wake (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(state_r == ppsc_pkg::ST_SLEEP),
    .pattern(energy_det && (send_s_det || send_t_det)),
    .wake_r(line_wake)
  );

  // ==========================================
  // Register access decode
  // Writes need the port alive, which is never the case in sleep
  assign wr_cfg = bus.wr_stb && reg_hit(bus.addr, ppsc_pkg::ADDR_CFG);
  assign wr_cmd = bus.wr_stb && reg_hit(bus.addr, ppsc_pkg::ADDR_CMD);
  assign wr_prep_a = bus.wr_stb && reg_hit(bus.addr, ppsc_pkg::ADDR_PREP_A);
  assign wr_prep_b = bus.wr_stb && reg_hit(bus.addr, ppsc_pkg::ADDR_PREP_B);
  assign cmd_start = wr_cmd && bus.wdata == ppsc_pkg::CMD_TO_NORMAL;
  assign cmd_stop = wr_cmd && bus.wdata == ppsc_pkg::CMD_TO_STANDBY;
  assign auton_set = wr_cfg && bus.wdata[ppsc_pkg::CFG_AUTON_BIT];
  assign bus.enable = en_r;

  // Autonomous bit reads back the strap as well
  always_comb begin
    bus.rdata = 16'h0000;
    if (reg_hit(bus.addr, ppsc_pkg::ADDR_CFG)) begin
      bus.rdata = cfg_r;
      bus.rdata[ppsc_pkg::CFG_AUTON_BIT] = cfg_r[ppsc_pkg::CFG_AUTON_BIT] || auton_strap_r;
    end else if (reg_hit(bus.addr, ppsc_pkg::ADDR_CMD)) begin
      bus.rdata = cmd_r;
    end else if (reg_hit(bus.addr, ppsc_pkg::ADDR_PREP_A)) begin
      bus.rdata = prep_a_r;
    end else if (reg_hit(bus.addr, ppsc_pkg::ADDR_PREP_B)) begin
      bus.rdata = prep_b_r;
    end
  end

  // ==========================================
  // Sleep entry conditions
  assign armed = cfg_r[ppsc_pkg::CFG_SLEEP_BIT] && !wake_in;
  assign prep_ok = prep_a_r == ppsc_pkg::PREP_A_SLEEP && prep_b_r == ppsc_pkg::PREP_B_SLEEP;
  // Slave role must have the remote bit cleared for a local entry
  assign local_go = armed && prep_ok
                    && (master_r || !cfg_r[ppsc_pkg::CFG_REMOTE_BIT]);
  // Quiet line: master needs the remote bit; a slave only needs silence
  assign remote_go = armed && !energy_det
                     && (master_r ? cfg_r[ppsc_pkg::CFG_REMOTE_BIT] : 1'b1);
  assign sleep_go = local_go || remote_go;

  // ==========================================
  // Power state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ppsc_pkg::ST_STANDBY: begin
        if (boot_r) begin
          state_nxt = strap_autonomous ? ppsc_pkg::ST_NORMAL : ppsc_pkg::ST_STANDBY;
        end else if (cmd_start) begin
          state_nxt = ppsc_pkg::ST_NORMAL;
        end else if (auton_set) begin
          state_nxt = ppsc_pkg::ST_NORMAL;
        end
      end
      ppsc_pkg::ST_NORMAL: begin
        if (cmd_stop) begin
          state_nxt = ppsc_pkg::ST_STANDBY;
        end else if (sleep_go) begin
          state_nxt = ppsc_pkg::ST_SLEEP_WAIT;
        end
      end
      ppsc_pkg::ST_SLEEP_WAIT: begin
        if (wake_in) begin
          state_nxt = ppsc_pkg::ST_NORMAL;
        end else if (supply_off) begin
          state_nxt = ppsc_pkg::ST_SLEEP;
        end
      end
      ppsc_pkg::ST_SLEEP: begin
        if (wake_in || line_wake) begin
          state_nxt = ppsc_pkg::ST_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ppsc_pkg::ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Straps are caught on the first clock after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      boot_r <= 1'b1;
      master_r <= 1'b0;
      auton_strap_r <= 1'b0;
    end else if (boot_r) begin
      boot_r <= 1'b0;
      master_r <= strap_master;
      auton_strap_r <= strap_autonomous;
    end
  end

  // ==========================================
  // Registers
  // Entering sleep wipes everything; the clear outranks a late write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= ppsc_pkg::CFG_RST;
      cmd_r <= ppsc_pkg::CMD_RST;
      prep_a_r <= ppsc_pkg::PREP_RST;
      prep_b_r <= ppsc_pkg::PREP_RST;
    end else if (state_nxt == ppsc_pkg::ST_SLEEP) begin
      cfg_r <= ppsc_pkg::CFG_RST;
      cmd_r <= ppsc_pkg::CMD_RST;
      prep_a_r <= ppsc_pkg::PREP_RST;
      prep_b_r <= ppsc_pkg::PREP_RST;
    end else begin
      if (wr_cfg) begin
        cfg_r <= bus.wdata;
      end
      // Only an accepted command is kept, so it reads back the last move
      if ((cmd_start && state_r == ppsc_pkg::ST_STANDBY)
          || (cmd_stop && state_r == ppsc_pkg::ST_NORMAL)) begin
        cmd_r <= bus.wdata;
      end
      if (wr_prep_a) begin
        prep_a_r <= bus.wdata;
      end
      if (wr_prep_b) begin
        prep_b_r <= bus.wdata;
      end
    end
  end

  // ==========================================
  // Outputs, registered from the next state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pcs_pma_en <= 1'b0;
      supply_inhibit_out <= 1'b0;
      power_state <= ppsc_pkg::ST_STANDBY;
      en_r <= 1'b1;
    end else begin
      pcs_pma_en <= state_nxt == ppsc_pkg::ST_NORMAL;
      supply_inhibit_out <= state_nxt == ppsc_pkg::ST_SLEEP_WAIT
                            || state_nxt == ppsc_pkg::ST_SLEEP;
      power_state <= state_nxt;
      en_r <= state_nxt != ppsc_pkg::ST_SLEEP;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  boot_standby_a: assert property (
    boot_r && !strap_autonomous |=> state_r == ppsc_pkg::ST_STANDBY && !pcs_pma_en)
    else $error("managed boot did not rest in standby");

  boot_normal_a: assert property (
    boot_r && strap_autonomous |=> state_r == ppsc_pkg::ST_NORMAL && pcs_pma_en)
    else $error("autonomous boot did not reach normal");

  standby_off_a: assert property (
    state_r == ppsc_pkg::ST_STANDBY |-> !pcs_pma_en && en_r && !supply_inhibit_out)
    else $error("standby with sublayers on or port off");

  auton_write_a: assert property (
    state_r == ppsc_pkg::ST_STANDBY && !boot_r && auton_set
    |=> state_r == ppsc_pkg::ST_NORMAL && pcs_pma_en)
    else $error("autonomous bit did not start normal");

  start_cmd_a: assert property (
    state_r == ppsc_pkg::ST_STANDBY && !boot_r && cmd_start
    |=> state_r == ppsc_pkg::ST_NORMAL && pcs_pma_en)
    else $error("start command did not reach normal");

  strap_catch_a: assert property (
    boot_r |=> !boot_r && master_r == $past(strap_master)
    && auton_strap_r == $past(strap_autonomous))
    else $error("straps not caught after reset");

  normal_on_a: assert property (
    state_r == ppsc_pkg::ST_NORMAL |-> pcs_pma_en && en_r && !supply_inhibit_out)
    else $error("normal with sublayers off or inhibit on");

  stop_cmd_a: assert property (
    state_r == ppsc_pkg::ST_NORMAL && cmd_stop
    |=> state_r == ppsc_pkg::ST_STANDBY && !pcs_pma_en)
    else $error("stop command did not force standby");

  ignore_cmd_a: assert property (
    state_r == ppsc_pkg::ST_STANDBY && !boot_r && wr_cmd && !cmd_start
    |=> $stable(state_r) && $stable(cmd_r))
    else $error("illegal command changed the state");

  ignore_norm_a: assert property (
    state_r == ppsc_pkg::ST_NORMAL && wr_cmd && !cmd_stop
    |=> $stable(cmd_r) && state_r != ppsc_pkg::ST_STANDBY)
    else $error("illegal command acted in normal");

  local_sleep_a: assert property (
    state_r == ppsc_pkg::ST_NORMAL && !wr_cmd && local_go
    |=> state_r == ppsc_pkg::ST_SLEEP_WAIT && supply_inhibit_out)
    else $error("prepared local sleep did not start");

  remote_sleep_a: assert property (
    state_r == ppsc_pkg::ST_NORMAL && !wr_cmd && armed && !energy_det
    && (!master_r || cfg_r[ppsc_pkg::CFG_REMOTE_BIT])
    |=> state_r == ppsc_pkg::ST_SLEEP_WAIT && supply_inhibit_out && !pcs_pma_en)
    else $error("quiet line did not start sleep entry");

  supply_hold_a: assert property (
    state_r == ppsc_pkg::ST_SLEEP_WAIT && !supply_off && !wake_in
    |=> state_r == ppsc_pkg::ST_SLEEP_WAIT && supply_inhibit_out)
    else $error("sleep entered with supplies still on");

  sleep_entry_a: assert property (
    $rose(state_r == ppsc_pkg::ST_SLEEP) |-> $past(supply_off) && !$past(wake_in))
    else $error("sleep entered without supply removal");

  sleep_lost_a: assert property (
    state_r == ppsc_pkg::ST_SLEEP |-> cfg_r == ppsc_pkg::CFG_RST
    && prep_a_r == ppsc_pkg::PREP_RST && !en_r && !pcs_pma_en)
    else $error("registers or port survived sleep");

  local_wake_a: assert property (
    state_r == ppsc_pkg::ST_SLEEP && wake_in
    |=> state_r == ppsc_pkg::ST_NORMAL && !supply_inhibit_out && en_r)
    else $error("wake input did not leave sleep");

  line_wake_a: assert property (
    state_r == ppsc_pkg::ST_SLEEP && line_wake |=> state_r == ppsc_pkg::ST_NORMAL)
    else $error("qualified line pattern did not leave sleep");

  start_seen_c: cover property (
    state_r == ppsc_pkg::ST_STANDBY && cmd_start ##1 state_r == ppsc_pkg::ST_NORMAL);
  force_standby_c: cover property (
    state_r == ppsc_pkg::ST_NORMAL ##1 state_r == ppsc_pkg::ST_STANDBY);
  sleep_reached_c: cover property (
    state_r == ppsc_pkg::ST_SLEEP_WAIT ##1 state_r == ppsc_pkg::ST_SLEEP);
  send_s_wake_c: cover property (
    state_r == ppsc_pkg::ST_SLEEP && line_wake && send_s_det ##1 state_r == ppsc_pkg::ST_NORMAL);
  send_t_wake_c: cover property (
    state_r == ppsc_pkg::ST_SLEEP && line_wake && send_t_det ##1 state_r == ppsc_pkg::ST_NORMAL);
endmodule

// ---- ppsc_line_partner.sv ----
// Model of the cable partner and the supply switch facing the controller
`timescale 1ns/100ps
module ppsc_line_partner (
  input wire logic clk_sys,
  input wire logic supply_inhibit_out,
  input wire logic [1:0] mode,
  output logic energy_det,
  output logic send_s_det,
  output logic send_t_det,
  output logic supply_off
);
  // ==========================================
  // Line symbols: mode 0 is a partner held quiet in managed mode
  logic [1:0] off_cnt_r;
  assign energy_det = (mode != 2'h0);
  assign send_s_det = (mode == 2'h2);
  assign send_t_det = (mode == 2'h3);
  // ==========================================
  // Supply switch: slow on purpose, so the wait for supply removal shows
  always_ff @(posedge clk_sys) begin
    if (!supply_inhibit_out) begin
      off_cnt_r <= 2'h0;
    end else if (off_cnt_r != 2'h3) begin
      off_cnt_r <= off_cnt_r + 2'h1;
    end
  end
  assign supply_off = supply_inhibit_out && (off_cnt_r == 2'h3);
endmodule

// ---- phy_power_state_control_tb.sv ----
// Self-checking bench for the power-state controller
`timescale 1ns/100ps
module phy_power_state_control_tb;
  localparam int HOLD = 8;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic strap_autonomous = 1'b0;
  logic strap_master = 1'b0;
  logic wake_in = 1'b1;
  logic mdc = 1'b0;
  logic host_oe = 1'b1;
  logic host_val = 1'b1;
  logic [1:0] lmode = 2'h0;
  logic mdio_in, mdio_out, mdio_oe, supply_inhibit_out, pcs_pma_en;
  logic energy_det, send_s_det, send_t_det, supply_off;
  logic [1:0] power_state;
  logic [15:0] rd;
  int errors = 0;
  int n_checks = 0;
  always #25 clk_sys = ~clk_sys;
  // Pull-up when neither side drives the data pin
  assign mdio_in = mdio_oe ? mdio_out : (host_oe ? host_val : 1'b1);
  ppsc_top #(.WAKE_HOLD_CYC(HOLD), .PORT_ADDR(5'h00)) dut_u (.clk_sys(clk_sys),
    .rst_b(rst_b), .strap_autonomous(strap_autonomous), .strap_master(strap_master),
    .wake_in(wake_in), .energy_det(energy_det), .send_s_det(send_s_det),
    .send_t_det(send_t_det), .supply_off(supply_off), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .supply_inhibit_out(supply_inhibit_out),
    .pcs_pma_en(pcs_pma_en), .power_state(power_state));
  ppsc_line_partner partner_u (.clk_sys(clk_sys), .supply_inhibit_out(supply_inhibit_out),
    .mode(lmode), .energy_det(energy_det), .send_s_det(send_s_det),
    .send_t_det(send_t_det), .supply_off(supply_off));
  // ==========================================
  // Checks and verdict
  task automatic stop_test();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input logic [1:0] st, input logic en);
    n_checks++;
    if ({pcs_pma_en, power_state} !== {en, st}) begin
      errors++;
      $display("[FAIL] %0t state %b %b exp %b %b", $time, pcs_pma_en, power_state, en, st);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_st(input logic [1:0] st, input logic en);
    int k;
    k = 0;
    while (power_state !== st && k < 40) begin
      cyc(1);
      k++;
    end
    chk_st(st, en);
    if (power_state !== st) stop_test();
  endtask
  task automatic boot(input logic au, input logic ms);
    strap_autonomous = au;
    strap_master = ms;
    rst_b = 1'b0;
    cyc(6);
    rst_b = 1'b1;
    cyc(3);
  endtask
  // ==========================================
  // Management frames; mdc runs at a quarter of the system clock
  task automatic mbit(input logic b);
    host_val = b;
    mdc = 1'b0;
    cyc(2);
    mdc = 1'b1;
    cyc(2);
  endtask
  task automatic frame(input logic [1:0] op, input logic [15:0] d);
    logic [31:0] w;
    w = {2'h0, op, 5'h00, 5'h01, 2'h2, d};
    host_oe = 1'b1;
    repeat (32) mbit(1'b1);
    for (int i = 31; i >= 0; i--) begin
      if (op[1] && i == 17) host_oe = 1'b0;
      mbit(w[i]);
      if (op[1] && i >= 1 && i <= 16) rd[i-1] = mdio_in;
    end
    host_oe = 1'b1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    frame(2'h0, a);
    frame(2'h1, d);
    cyc(2);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    frame(2'h0, a);
    frame(2'h3, 16'h0000);
    chk_word(rd, exp);
  endtask
  // ==========================================
  // Scenarios
  initial begin
    boot(1'b0, 1'b0);
    chk_st(ppsc_pkg::ST_STANDBY, 1'b0);
    rd_chk(ppsc_pkg::ADDR_CFG, 16'h0000);
    rd_chk(16'h0200, 16'h0000);
    wr(ppsc_pkg::ADDR_CMD, ppsc_pkg::CMD_TO_STANDBY);
    wr(ppsc_pkg::ADDR_CMD, 16'h0002);
    chk_st(ppsc_pkg::ST_STANDBY, 1'b0);
    rd_chk(ppsc_pkg::ADDR_CMD, 16'h0000);
    wr(ppsc_pkg::ADDR_CMD, ppsc_pkg::CMD_TO_NORMAL);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    wr(ppsc_pkg::ADDR_CMD, 16'h0003);
    rd_chk(ppsc_pkg::ADDR_CMD, ppsc_pkg::CMD_TO_NORMAL);
    wr(ppsc_pkg::ADDR_CMD, ppsc_pkg::CMD_TO_STANDBY);
    chk_st(ppsc_pkg::ST_STANDBY, 1'b0);
    rd_chk(ppsc_pkg::ADDR_CMD, 16'h0010);
    wr(ppsc_pkg::ADDR_CFG, 16'h0040);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    // Slave local sleep; line stays busy so only the local path can fire
    lmode = 2'h1;
    wr(ppsc_pkg::ADDR_CFG, 16'h00c0);
    wr(ppsc_pkg::ADDR_PREP_B, ppsc_pkg::PREP_B_SLEEP);
    wr(ppsc_pkg::ADDR_PREP_A, ppsc_pkg::PREP_A_SLEEP);
    rd_chk(ppsc_pkg::ADDR_PREP_A, 16'h0100);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    wake_in = 1'b0;
    wait_st(ppsc_pkg::ST_SLEEP_WAIT, 1'b0);
    chk_word({15'h0000, supply_inhibit_out}, 16'h0001);
    wait_st(ppsc_pkg::ST_SLEEP, 1'b0);
    rd_chk(ppsc_pkg::ADDR_CFG, 16'hffff);
    wake_in = 1'b1;
    wait_st(ppsc_pkg::ST_NORMAL, 1'b1);
    rd_chk(ppsc_pkg::ADDR_CFG, 16'h0000);
    // Slave remote sleep, then wake by line patterns
    wr(ppsc_pkg::ADDR_CFG, 16'h0080);
    wake_in = 1'b0;
    cyc(6);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    lmode = 2'h0;
    wait_st(ppsc_pkg::ST_SLEEP, 1'b0);
    lmode = 2'h2;
    cyc(HOLD - 2);
    lmode = 2'h0;
    cyc(4);
    chk_st(ppsc_pkg::ST_SLEEP, 1'b0);
    lmode = 2'h2;
    cyc(HOLD + 3);
    lmode = 2'h0;
    wait_st(ppsc_pkg::ST_NORMAL, 1'b1);
    wr(ppsc_pkg::ADDR_CFG, 16'h0080);
    wait_st(ppsc_pkg::ST_SLEEP, 1'b0);
    lmode = 2'h3;
    cyc(HOLD + 3);
    lmode = 2'h0;
    wait_st(ppsc_pkg::ST_NORMAL, 1'b1);
    // Master local sleep ignores the remote bit
    wake_in = 1'b1;
    lmode = 2'h1;
    boot(1'b0, 1'b1);
    chk_st(ppsc_pkg::ST_STANDBY, 1'b0);
    wr(ppsc_pkg::ADDR_CMD, ppsc_pkg::CMD_TO_NORMAL);
    wr(ppsc_pkg::ADDR_CFG, 16'h0180);
    wr(ppsc_pkg::ADDR_PREP_B, ppsc_pkg::PREP_B_SLEEP);
    wr(ppsc_pkg::ADDR_PREP_A, ppsc_pkg::PREP_A_SLEEP);
    wake_in = 1'b0;
    wait_st(ppsc_pkg::ST_SLEEP, 1'b0);
    wake_in = 1'b1;
    wait_st(ppsc_pkg::ST_NORMAL, 1'b1);
    // Master put to sleep remotely by loss of line energy
    wr(ppsc_pkg::ADDR_CFG, 16'h0180);
    wake_in = 1'b0;
    cyc(6);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    lmode = 2'h0;
    wait_st(ppsc_pkg::ST_SLEEP, 1'b0);
    wake_in = 1'b1;
    wait_st(ppsc_pkg::ST_NORMAL, 1'b1);
    boot(1'b1, 1'b0);
    chk_st(ppsc_pkg::ST_NORMAL, 1'b1);
    // Autonomous bit reads the strap; read-increment then reaches the command word
    rd_chk(ppsc_pkg::ADDR_CFG, 16'h0040);
    frame(2'h2, 16'h0000);
    chk_word(rd, 16'h0040);
    frame(2'h3, 16'h0000);
    chk_word(rd, ppsc_pkg::CMD_RST);
    stop_test();
  end
endmodule
